// ==== logic/pfsel_pkg.sv ====
// Package for the port F output and function select block.
// Assumes a classic Wishbone slave with 32-bit data and byte offsets.
`default_nettype none
package pfsel_pkg;
    // Register byte offsets
    localparam logic [5:0] OFS_OUT_EN = 6'h04;
    localparam logic [5:0] OFS_FSEL_A = 6'h08;
    localparam logic [5:0] OFS_FSEL_B = 6'h0c;
    localparam logic [5:0] OFS_FSEL_C = 6'h10;
    localparam logic [5:0] OFS_OD_SEL = 6'h28;
    // Writable bit masks per register
    localparam logic [7:0] MASK_OUT_EN = 8'hff;
    localparam logic [7:0] MASK_FSEL_A = 8'hfe;
    localparam logic [7:0] MASK_FSEL_B = 8'h30;
    localparam logic [7:0] MASK_FSEL_C = 8'h31;
    localparam logic [7:0] MASK_OD_SEL = 8'hff;
    // Reset value of every register
    localparam logic [7:0] RST_VAL = 8'h00;
    // Field positions
    localparam int BIT_LATCH_STROBE = 7;
    localparam int BIT_CS_ZERO = 6;
    localparam int BIT_CS_ONE = 5;
    localparam int BIT_UPPER_BE = 4;
    localparam int BIT_LOWER_BE = 3;
    localparam int BIT_READ_STROBE = 1;
    localparam int BIT_IRQ_SEVEN = 5;
    localparam int BIT_IRQ_SIX = 4;
    localparam int BIT_T5_CAP_B = 5;
    localparam int BIT_T5_CAP_A = 4;
    localparam int BIT_T6_OUT = 0;
    // Bus answer state
    typedef enum logic [0:0] {
        PFSEL_IDLE = 1'b0,
        PFSEL_ACK = 1'b1
    } pfsel_bus_t;
endpackage
`default_nettype wire

// ==== logic/pfsel_reg8.sv ====
// One 8-bit configuration register with byte-lane write and a bit mask.
// Assumes the write strobe is a single-cycle pulse on CLK_I.
`timescale 1ns/100ps
`default_nettype none
module pfsel_reg8 #(
    parameter logic [7:0] MASK = 8'hff
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire logic [7:0] data_i,
    output logic [7:0] q_o
);
    logic [7:0] next_q; // Next register value

    // Unmasked bits never store, so they read zero
    always_comb begin
        next_q = q_o;
        if (wr_i) begin
            next_q = data_i & MASK;
        end
    end

    // Register stage, cleared by reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_o <= pfsel_pkg::RST_VAL;
        end else begin
            q_o <= next_q;
        end
    end
endmodule // pfsel_reg8
`default_nettype wire

// ==== logic/pfsel_top.sv ====
// Port F pin configuration: output enable, three function selects,
// open-drain select, and the per-pin routing they imply.
// Assumes a classic Wishbone master on CLK_I and synchronous RST_I.
// Register map, byte offsets on the 6-bit address:
//   0x04 pin output enable, all eight bits writable
//   0x08 function select A, bit 0 has no storage
//   0x0c function select B, only bits 5 and 4 stored
//   0x10 function select C, bits 5, 4 and 0 stored
//   0x28 open-drain select, all eight bits writable
// Every other offset answers with zero and drops writes.
// Reserved offsets are harmless to touch here; they simply read zero.
// Only byte lane 0 carries storage; lanes 1 to 3 are ignored.
//
// Select A claims pins for the external bus strobes, select B for
// two external interrupt inputs, select C for timer capture inputs
// and one timer output. A pin with no select bit set stays plain.
//
// Pin views lag the registers by one clock, since every output
// leaves through its own flip-flop. Software that writes a select
// and then samples a pin must allow for that one cycle.
`timescale 1ns/100ps
`default_nettype none
module pfsel_top (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [5:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    output logic [7:0] OUTPUT_ENABLE_BITS_O,
    output logic [7:0] OPEN_DRAIN_BITS_O,
    output logic [7:0] GPIO_MODE_O,
    output logic LATCH_STROBE_SELECT_O,
    output logic CHIP_SELECT_ZERO_O,
    output logic CHIP_SELECT_ONE_O,
    output logic UPPER_BYTE_ENABLE_O,
    output logic LOWER_BYTE_ENABLE_O,
    output logic READ_STROBE_SELECT_O,
    output logic EXTERNAL_IRQ_SEVEN_O,
    output logic EXTERNAL_IRQ_SIX_O,
    output logic TIMER5_CAPTURE_INPUT_B_O,
    output logic TIMER5_CAPTURE_INPUT_A_O,
    output logic TIMER6_OUTPUT_O
);
    // Bus side state: answer phase and the word it returns
    pfsel_pkg::pfsel_bus_t state; // Bus answer state
    pfsel_pkg::pfsel_bus_t next_state;
    logic [31:0] rdata; // Registered read data
    logic [31:0] next_rdata;
    logic [7:0] out_en; // pin_output_enable
    logic [7:0] fsel_a; // alt_function_select_a
    logic [7:0] fsel_b; // alt_function_select_b
    logic [7:0] fsel_c; // alt_function_select_c
    logic [7:0] od_sel; // open_drain_select
    logic req; // New request seen in idle
    logic wr_lane0; // Write touching the low byte
    // Output stage: every pin view leaves through a flip-flop
    logic [7:0] pin_oe; // Registered pin views
    logic [7:0] pin_od;
    logic [7:0] pin_gpio;
    logic [10:0] alt; // Registered alternate selects
    logic [7:0] next_pin_gpio;
    logic [10:0] next_alt;

    // Decode helper: a write to the low byte of one register
    // Full six-bit compare, so no register shows an alias at the
    // reserved offsets that lie between them.
    function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
        hit = (a == o);
    endfunction

    // A request counts only while idle, so the ack cycle never
    // takes again the request that the master is still holding
    assign req = CYC_I && STB_I && (state == pfsel_pkg::PFSEL_IDLE);
    // Only bits 7:0 are implemented, so only lane 0 can write
    assign wr_lane0 = req && WE_I && SEL_I[0];

    // Register instances, one per configuration word. Each keeps only
    // its masked bits, so the zero read-back of unused bits comes for
    // free and needs no separate read mask in the answer path.
    // Output enable: one bit per pin driver
    pfsel_reg8 #(.MASK(pfsel_pkg::MASK_OUT_EN)) u_out_en (
        .clk_i(CLK_I), .rst_i(RST_I),
        .wr_i(wr_lane0 && hit(ADR_I, pfsel_pkg::OFS_OUT_EN)),
        .data_i(DAT_I[7:0]), .q_o(out_en));
    // Select A: external bus strobes and chip selects
    pfsel_reg8 #(.MASK(pfsel_pkg::MASK_FSEL_A)) u_fsel_a (
        .clk_i(CLK_I), .rst_i(RST_I),
        .wr_i(wr_lane0 && hit(ADR_I, pfsel_pkg::OFS_FSEL_A)),
        .data_i(DAT_I[7:0]), .q_o(fsel_a));
    // Select B: external interrupt inputs
    pfsel_reg8 #(.MASK(pfsel_pkg::MASK_FSEL_B)) u_fsel_b (
        .clk_i(CLK_I), .rst_i(RST_I),
        .wr_i(wr_lane0 && hit(ADR_I, pfsel_pkg::OFS_FSEL_B)),
        .data_i(DAT_I[7:0]), .q_o(fsel_b));
    // Select C: timer capture inputs and timer output
    pfsel_reg8 #(.MASK(pfsel_pkg::MASK_FSEL_C)) u_fsel_c (
        .clk_i(CLK_I), .rst_i(RST_I),
        .wr_i(wr_lane0 && hit(ADR_I, pfsel_pkg::OFS_FSEL_C)),
        .data_i(DAT_I[7:0]), .q_o(fsel_c));
    // Open-drain select: one means open-drain for that pin
    pfsel_reg8 #(.MASK(pfsel_pkg::MASK_OD_SEL)) u_od_sel (
        .clk_i(CLK_I), .rst_i(RST_I),
        .wr_i(wr_lane0 && hit(ADR_I, pfsel_pkg::OFS_OD_SEL)),
        .data_i(DAT_I[7:0]), .q_o(od_sel));

    // Bus answer: one wait state, ack for exactly one cycle.
    // A request is taken on the edge where cycle and strobe are high
    // and the slave is idle; the write lands on that same edge. Ack
    // then stands for one cycle; read data holds until the next take. The ack state blocks a
    // second take while the master still holds its request, so a
    // master that keeps strobe up into the ack cycle is served once.
    always_comb begin
        next_state = pfsel_pkg::PFSEL_IDLE;
        next_rdata = rdata;
        case (state)
            pfsel_pkg::PFSEL_IDLE: begin
                if (req) begin
                    next_state = pfsel_pkg::PFSEL_ACK;
                    next_rdata = 32'h0000_0000; // Unmapped reads zero
                    case (ADR_I)
                        pfsel_pkg::OFS_OUT_EN: next_rdata[7:0] = out_en;
                        pfsel_pkg::OFS_FSEL_A: next_rdata[7:0] = fsel_a;
                        pfsel_pkg::OFS_FSEL_B: next_rdata[7:0] = fsel_b;
                        pfsel_pkg::OFS_FSEL_C: next_rdata[7:0] = fsel_c;
                        pfsel_pkg::OFS_OD_SEL: next_rdata[7:0] = od_sel;
                        default: next_rdata = 32'h0000_0000;
                    endcase
                end
            end
            pfsel_pkg::PFSEL_ACK: begin
                next_state = pfsel_pkg::PFSEL_IDLE; // Drop ack next cycle
            end
            default: next_state = pfsel_pkg::PFSEL_IDLE;
        endcase
    end

    // Answer state and read word registers; reset leaves the bus
    // quiet with ack low and the read word at zero, so a master
    // that polls during reset never sees a stale answer
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            state <= pfsel_pkg::PFSEL_IDLE;
            rdata <= 32'h0000_0000;
        end else begin
            state <= next_state;
            rdata <= next_rdata;
        end
    end

    // Pin routing; no priority needed since software keeps one bit set
    // A pin is plain only while none of the three selects claims it.
    // Several selects on one pin are passed through as they stand:
    // the owning peripherals see them all, and sorting that out is
    // left to software, which must keep to one function per pin.
    always_comb begin
        next_pin_gpio = ~(fsel_a | fsel_b | fsel_c);
        next_alt = {fsel_a[pfsel_pkg::BIT_LATCH_STROBE],
                    fsel_a[pfsel_pkg::BIT_CS_ZERO],
                    fsel_a[pfsel_pkg::BIT_CS_ONE],
                    fsel_a[pfsel_pkg::BIT_UPPER_BE],
                    fsel_a[pfsel_pkg::BIT_LOWER_BE],
                    fsel_a[pfsel_pkg::BIT_READ_STROBE],
                    fsel_b[pfsel_pkg::BIT_IRQ_SEVEN],
                    fsel_b[pfsel_pkg::BIT_IRQ_SIX],
                    fsel_c[pfsel_pkg::BIT_T5_CAP_B],
                    fsel_c[pfsel_pkg::BIT_T5_CAP_A],
                    fsel_c[pfsel_pkg::BIT_T6_OUT]};
    end

    // Output stage; reset gives plain pins with drivers off
    // Pin 0 comes out of reset as a plain pin with its driver off as
    // well; its pull-up belongs to a register outside this block.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            pin_oe <= pfsel_pkg::RST_VAL;
            pin_od <= pfsel_pkg::RST_VAL;
            pin_gpio <= ~pfsel_pkg::RST_VAL;
            alt <= 11'h000;
        end else begin
            pin_oe <= out_en;
            pin_od <= od_sel;
            pin_gpio <= next_pin_gpio;
            alt <= next_alt;
        end
    end

    // Bus side outputs
    assign DAT_O = rdata;
    assign ACK_O = (state == pfsel_pkg::PFSEL_ACK);
    // Pin driver views, one bit per pin
    assign OUTPUT_ENABLE_BITS_O = pin_oe;
    assign OPEN_DRAIN_BITS_O = pin_od;
    assign GPIO_MODE_O = pin_gpio;
    // External bus strobes from select A
    assign LATCH_STROBE_SELECT_O = alt[10];
    assign CHIP_SELECT_ZERO_O = alt[9];
    assign CHIP_SELECT_ONE_O = alt[8];
    assign UPPER_BYTE_ENABLE_O = alt[7];
    assign LOWER_BYTE_ENABLE_O = alt[6];
    assign READ_STROBE_SELECT_O = alt[5];
    // Interrupt inputs from select B
    assign EXTERNAL_IRQ_SEVEN_O = alt[4];
    assign EXTERNAL_IRQ_SIX_O = alt[3];
    // Timer lines from select C
    assign TIMER5_CAPTURE_INPUT_B_O = alt[2];
    assign TIMER5_CAPTURE_INPUT_A_O = alt[1];
    assign TIMER6_OUTPUT_O = alt[0];
endmodule // pfsel_top
`default_nettype wire

// ==== tb/pfsel_chk.sv ====
// Checker for the port F select block: bus answer and pin outputs.
// Assumes it is bound into pfsel_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module pfsel_chk (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic ACK_O,
    input wire logic [5:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    input wire logic [31:0] DAT_O,
    input wire logic LATCH_STROBE_SELECT_O,
    input wire logic EXTERNAL_IRQ_SEVEN_O,
    input wire logic TIMER6_OUTPUT_O,
    input wire logic [7:0] OUTPUT_ENABLE_BITS_O,
    input wire logic [7:0] OPEN_DRAIN_BITS_O,
    input wire logic [7:0] GPIO_MODE_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // Request taken while the slave is idle
    wire logic tk = CYC_I && STB_I && !ACK_O;
    // Lane 0 write, the only lane that stores
    wire logic wr = tk && WE_I && SEL_I[0];
    property p_ack; tk |=> ACK_O ##1 !ACK_O; endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle");
    property p_oe;
        wr && ADR_I == 6'h04 |=> ##1
            OUTPUT_ENABLE_BITS_O == $past(DAT_I[7:0], 2);
    endproperty
    a_oe: assert property (p_oe) else $error("output enable wrong");
    property p_od;
        wr && ADR_I == 6'h28 |=> ##1 OPEN_DRAIN_BITS_O == $past(DAT_I[7:0], 2);
    endproperty
    a_od: assert property (p_od) else $error("open drain wrong");
    property p_irq;
        wr && ADR_I == 6'h0c |=> ##1
            EXTERNAL_IRQ_SEVEN_O == $past(DAT_I[5], 2);
    endproperty
    a_irq: assert property (p_irq) else $error("irq seven wrong");
    property p_t6;
        wr && ADR_I == 6'h10 |=> ##1 TIMER6_OUTPUT_O == $past(DAT_I[0], 2);
    endproperty
    a_t6: assert property (p_t6) else $error("timer output wrong");
    // Just out of reset every pin is plain with its driver off
    property p_rst;
        $fell(RST_I) |-> OUTPUT_ENABLE_BITS_O == 8'h00 && GPIO_MODE_O == 8'hff;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_rd0;
        ACK_O && !$past(WE_I) && $past(ADR_I) == 6'h08 |-> !DAT_O[0];
    endproperty
    a_rd0: assert property (p_rd0) else $error("select a bit 0 set");
    // Pin 7 has only the strobe select, so plain mode mirrors it
    property p_gp7; GPIO_MODE_O[7] == !LATCH_STROBE_SELECT_O; endproperty
    a_gp7: assert property (p_gp7) else $error("pin 7 mode wrong");
endmodule // pfsel_chk
bind pfsel_top pfsel_chk pfsel_chk_inst (.CLK_I(CLK_I), .RST_I(RST_I),
    .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ACK_O(ACK_O), .ADR_I(ADR_I),
    .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
    .LATCH_STROBE_SELECT_O(LATCH_STROBE_SELECT_O),
    .EXTERNAL_IRQ_SEVEN_O(EXTERNAL_IRQ_SEVEN_O),
    .TIMER6_OUTPUT_O(TIMER6_OUTPUT_O),
    .OUTPUT_ENABLE_BITS_O(OUTPUT_ENABLE_BITS_O),
    .OPEN_DRAIN_BITS_O(OPEN_DRAIN_BITS_O), .GPIO_MODE_O(GPIO_MODE_O));
`default_nettype wire

// ==== tb/pfsel_top_bench.sv ====
// Bench for the port F select block: register tasks and pin checks.
// Assumes the Wishbone answer comes one cycle after a request is taken.
`timescale 1ns/100ps
`default_nettype none
module pfsel_top_bench;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [5:0] adr = 6'h00;
    wire logic [5:0] sa; // Strobe select views, one port per bit
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_w = 32'h0, dat_r, rdat;
    logic [7:0] oe, od, gpio;
    logic irq7, irq6, t5b, t5a, t6;
    int n_fail = 0, total_checks = 0, cycles = 0;
    // Register table: offsets, writable bits, one-function-per-pin pattern
    logic [5:0] ofs [5] = '{6'h04, 6'h08, 6'h0c, 6'h10, 6'h28};
    logic [7:0] msk [5] = '{8'hff, 8'hfe, 8'h30, 8'h31, 8'hff};
    logic [7:0] pat [5] = '{8'h5a, 8'h4a, 8'h20, 8'h10, 8'ha5};
    pfsel_top pfsel_top_inst (.CLK_I(clk), .RST_I(rst), .CYC_I(cyc),
        .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w),
        .DAT_O(dat_r), .ACK_O(ack), .OUTPUT_ENABLE_BITS_O(oe),
        .OPEN_DRAIN_BITS_O(od), .GPIO_MODE_O(gpio),
        .LATCH_STROBE_SELECT_O(sa[5]), .CHIP_SELECT_ZERO_O(sa[4]),
        .CHIP_SELECT_ONE_O(sa[3]), .UPPER_BYTE_ENABLE_O(sa[2]),
        .LOWER_BYTE_ENABLE_O(sa[1]), .READ_STROBE_SELECT_O(sa[0]),
        .EXTERNAL_IRQ_SEVEN_O(irq7), .EXTERNAL_IRQ_SIX_O(irq6),
        .TIMER5_CAPTURE_INPUT_B_O(t5b), .TIMER5_CAPTURE_INPUT_A_O(t5a),
        .TIMER6_OUTPUT_O(t6));
    // 50 MHz clock
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One classic cycle; holds everything until ack is sampled
    task automatic acc(input logic w, input logic [5:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        sel <= s;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        rdat = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic results;
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Hang guard, far above the hundred or so cycles needed
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({oe, od, gpio}, 32'h0000ff);
        for (int i = 0; i < 5; i++) begin
            acc(1'b0, ofs[i], 32'h0, 4'hf);
            chk(rdat, 32'h0);
            acc(1'b1, ofs[i], 32'hffffffff, 4'hf);
            acc(1'b0, ofs[i], 32'h0, 4'hf);
            chk(rdat, {24'h0, msk[i]});
        end
        chk({oe, od, gpio}, 32'hffff00);
        chk({sa, irq7, irq6, t5b, t5a, t6}, 32'h7ff);
        // Lane 0 off leaves the register alone
        acc(1'b1, 6'h04, 32'h0, 4'he);
        acc(1'b0, 6'h04, 32'h0, 4'hf);
        chk(rdat, 32'hff);
        // Unmapped place stores nothing
        acc(1'b1, 6'h14, 32'hffffffff, 4'hf);
        acc(1'b0, 6'h14, 32'h0, 4'hf);
        chk(rdat, 32'h0);
        for (int i = 0; i < 5; i++)
            acc(1'b1, ofs[i], {24'hffffff, pat[i]}, 4'hf);
        chk({oe, od, gpio}, 32'h5aa585);
        chk({sa, irq7, irq6, t5b, t5a, t6}, 32'h272);
        // Reset in mid-run clears every register and returns the pin views to plain pins with drivers off
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({oe, od, gpio}, 32'h0000ff);
        chk({sa, irq7, irq6, t5b, t5a, t6}, 32'h000);
        for (int i = 0; i < 5; i++) begin
            acc(1'b0, ofs[i], 32'h0, 4'hf);
            chk(rdat, 32'h0);
        end
        results();
    end
endmodule // pfsel_top_bench
`default_nettype wire
